/* File: dv/tb.sv */
// bench for the limit and index register slice
// assumes the design and checker files are compiled first
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // signals and design
    // ------------------------------------------------------------
    logic        MCLK_I = 0;
    logic        ARST_N_I = 0;
    logic [5:0]  AVS_ADDRESS_I = 6'h00;
    logic        AVS_READ_I = 0;
    logic        AVS_WRITE_I = 0;
    logic [31:0] AVS_WRITEDATA_I = 32'h0;
    logic [3:0]  AVS_BYTEENABLE_I = 4'hF;
    logic        STEP_ADVANCE_I = 0;
    logic        STEP_JUMP_I = 0;
    logic [4:0]  STEP_JUMP_INDEX_I = 5'h00;
    logic [15:0] CNT0_VALUE_I = 16'h0;
    logic [31:0] AVS_READDATA_O;
    logic        AVS_WAITREQUEST_O, CNT0_AT_LIMIT_O, SEQ_BUSY_O, SEQ_ENABLE_O, SEQ_START_O;
    logic [15:0] LOOP_LIMIT_O, lim, qw;
    logic [4:0]  STEP_INDEX_O, jmp;
    logic [7:0]  STEP_CMD_O;
    logic [31:0] exp_q[$];
    int          num_errors = 0, checks_done = 0, seed = 32'h498c5f67;
    tss_limptr i_dut (.*);
    always #5 MCLK_I = ~MCLK_I;
    // compare, verdict and bus cycle tasks
    task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task stop_test;
        if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge MCLK_I);
        AVS_ADDRESS_I <= a;
        AVS_WRITE_I <= w;
        AVS_READ_I <= !w;
        AVS_WRITEDATA_I <= d;
        do begin
            @(posedge MCLK_I);
            n++;
        end while (AVS_WAITREQUEST_O !== 1'b0 && n < 20);
        if (AVS_WAITREQUEST_O !== 1'b0) begin
            num_errors++;
            stop_test;
        end
        AVS_READ_I <= 0;
        AVS_WRITE_I <= 0;
    endtask
    task rd(input logic [5:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(0, a, 32'h0);
    endtask
    // read results taken at the completing edge
    always @(posedge MCLK_I) begin
        if (AVS_READ_I && AVS_WAITREQUEST_O === 1'b0) begin
            if (exp_q.size() == 0) cmp("read queue", 32'h1, 32'h0);
            else cmp("readdata", exp_q.pop_front(), AVS_READDATA_O);
        end
    end
    // main sequence
    initial begin
        lim = 16'($random(seed));
        jmp = 5'($random(seed));
        repeat (12) @(posedge MCLK_I);
        ARST_N_I <= 1;
        rd(6'h00, 32'h0);
        rd(6'h04, 32'h0);
        qw = 16'($random(seed));
        bus(1, 6'h0C, {16'h0, qw});
        @(negedge MCLK_I);
        cmp("step cmd even", {24'h0, qw[7:0]}, {24'h0, STEP_CMD_O});
        bus(1, 6'h04, 32'h1);
        @(negedge MCLK_I);
        cmp("step cmd odd", {24'h0, qw[15:8]}, {24'h0, STEP_CMD_O});
        rd(6'h0C, {16'h0, qw});
        bus(1, 6'h00, {16'hFFFF, lim});
        rd(6'h00, {16'h0, lim});
        CNT0_VALUE_I <= lim;
        @(negedge MCLK_I);
        cmp("limit out", {16'h0, lim}, {16'h0, LOOP_LIMIT_O});
        cmp("at limit", 32'h1, {31'h0, CNT0_AT_LIMIT_O});
        bus(1, 6'h04, 32'hFFF5);
        rd(6'h04, 32'h15);
        bus(1, 6'h08, 32'h3);
        rd(6'h08, 32'h7);
        bus(1, 6'h00, {16'h0, ~lim});
        rd(6'h00, {16'h0, lim});
        bus(1, 6'h04, 32'h0);
        rd(6'h04, 32'h15);
        @(posedge MCLK_I) STEP_ADVANCE_I <= 1;
        @(posedge MCLK_I) STEP_ADVANCE_I <= 0;
        rd(6'h04, 32'h16);
        @(posedge MCLK_I) STEP_JUMP_I <= 1;
        STEP_JUMP_INDEX_I <= jmp;
        @(posedge MCLK_I) STEP_JUMP_I <= 0;
        rd(6'h04, {27'h0, jmp});
        bus(1, 6'h08, 32'h0);
        bus(1, 6'h00, 32'h0);
        rd(6'h00, 32'h0);
        rd(6'h3C, 32'h0);
        stop_test;
    end
endmodule

bind tss_limptr tss_limptr_sva #(.LIMIT_W(LIMIT_W), .INDEX_W(INDEX_W)) i_sva (.*);

`default_nettype wire

/* File: dv/tss_limptr_sva.sv */
// checker for the limit and index register slice
// assumes a bind onto tss_limptr from the bench top
`default_nettype none

module tss_limptr_sva #(
    parameter LIMIT_W = 16,
    parameter INDEX_W = 5
) (
    input wire logic               MCLK_I,
    input wire logic               ARST_N_I,
    input wire logic               AVS_READ_I,
    input wire logic               AVS_WRITE_I,
    input wire logic               AVS_WAITREQUEST_O,
    input wire logic               STEP_ADVANCE_I,
    input wire logic               STEP_JUMP_I,
    input wire logic [INDEX_W-1:0] STEP_JUMP_INDEX_I,
    input wire logic [LIMIT_W-1:0] CNT0_VALUE_I,
    input wire logic [LIMIT_W-1:0] LOOP_LIMIT_O,
    input wire logic               CNT0_AT_LIMIT_O,
    input wire logic [INDEX_W-1:0] STEP_INDEX_O,
    input wire logic               SEQ_BUSY_O,
    input wire logic               SEQ_ENABLE_O,
    input wire logic               SEQ_START_O
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!ARST_N_I);
    // one wait cycle per request, then done
    sequence s_req_open;
        $rose(AVS_READ_I || AVS_WRITE_I);
    endsequence
    sequence s_req_wait;
        (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
    endsequence
    a_wait_first: assert property (s_req_open |-> AVS_WAITREQUEST_O)
        else $error("no wait cycle on new request");
    a_wait_once: assert property (s_req_wait |=> !AVS_WAITREQUEST_O)
        else $error("request not finished after one wait");
    a_busy_both: assert property (SEQ_BUSY_O == (SEQ_ENABLE_O && SEQ_START_O))
        else $error("busy not enable and start");
    a_limit_frozen: assert property (SEQ_BUSY_O |=> $stable(LOOP_LIMIT_O))
        else $error("limit changed while busy");
    a_index_frozen: assert property (SEQ_BUSY_O && !STEP_ADVANCE_I && !STEP_JUMP_I
        |=> $stable(STEP_INDEX_O)) else $error("index moved without a step");
    a_index_idle: assert property (!SEQ_BUSY_O && !AVS_WRITE_I |=> $stable(STEP_INDEX_O))
        else $error("index moved while idle");
    a_index_step: assert property (SEQ_BUSY_O && STEP_ADVANCE_I && !STEP_JUMP_I
        |=> STEP_INDEX_O == INDEX_W'($past(STEP_INDEX_O) + 1))
        else $error("index did not advance by one");
    a_index_jump: assert property (SEQ_BUSY_O && STEP_JUMP_I
        |=> STEP_INDEX_O == $past(STEP_JUMP_INDEX_I)) else $error("index missed jump");
    a_at_limit: assert property (CNT0_AT_LIMIT_O == (CNT0_VALUE_I == LOOP_LIMIT_O))
        else $error("limit match flag wrong");
endmodule

`default_nettype wire

/* File: logic/tss_limptr.v */
// step sequencer counter 0 limit and step queue index registers
// assumes an avalon-mm master on the register port and one clock
`include "tss_limptr_defs.vh"
`default_nettype none

// Contract
// [RULE_01] a 16-bit counter 0 limit register feeds the loop count of the jump-on-counter-zero step.
// [RULE_02] the same limit value serves as terminal count of general purpose counter 0.
// [RULE_03] while enable and start are both set, software writes to limit and index are ignored.
// [RULE_04] a 5-bit step queue index in bits 4:0 is readable and writable while not executing.
// [RULE_05] the index always selects the step command currently executing in the queue.
// [RULE_06] index register bits 15:5 read as zero.
// [RULE_07] all sixteen limit bits form one read/write field loaded before starting.
// [RULE_08] the queue holds one 8-bit step per location, two packed in each 16-bit word.
// [RULE_09] both registers reset to zero and writes to unused index bits do nothing.
module tss_limptr #(
    parameter LIMIT_W = `TSS_LIMIT_W,
    parameter INDEX_W = `TSS_INDEX_W
) (
    input  wire                MCLK_I,
    input  wire                ARST_N_I,
    input  wire [5:0]          AVS_ADDRESS_I,
    input  wire                AVS_READ_I,
    input  wire                AVS_WRITE_I,
    input  wire [31:0]         AVS_WRITEDATA_I,
    input  wire [3:0]          AVS_BYTEENABLE_I,
    output reg  [31:0]         AVS_READDATA_O,
    output wire                AVS_WAITREQUEST_O,
    input  wire                STEP_ADVANCE_I,
    input  wire                STEP_JUMP_I,
    input  wire [INDEX_W-1:0]  STEP_JUMP_INDEX_I,
    input  wire [LIMIT_W-1:0]  CNT0_VALUE_I,
    output wire [LIMIT_W-1:0]  LOOP_LIMIT_O,
    output wire                CNT0_AT_LIMIT_O,
    output wire [INDEX_W-1:0]  STEP_INDEX_O,
    output wire [7:0]          STEP_CMD_O,
    output wire                SEQ_BUSY_O,
    output wire                SEQ_ENABLE_O,
    output wire                SEQ_START_O
);
    // ----------------------------------------------------------------
    // bus handshake
    // ----------------------------------------------------------------
    reg                 ack_reg;
    reg [LIMIT_W-1:0]   limit_reg;
    reg [INDEX_W-1:0]   index_reg;
    reg                 enable_reg;
    reg                 start_reg;
    wire                req;
    wire                wr_go;
    wire                rd_go;
    wire                busy;
    wire [3:0]          word_addr;
    wire [15:0]         q_rdata;
    wire [15:0]         wmask;

    // byte-enable expansion for the low 16 bits
    function [15:0] lane_mask;
        input [3:0] be;
        begin
            lane_mask = {{8{be[1]}}, {8{be[0]}}};
        end
    endfunction

    function [15:0] merge16;
        input [15:0] old_v;
        input [15:0] new_v;
        input [15:0] m;
        begin
            merge16 = (old_v & ~m) | (new_v & m);
        end
    endfunction

    assign req               = AVS_READ_I | AVS_WRITE_I;
    // one wait cycle, answer on the second edge of a request
    assign AVS_WAITREQUEST_O = req & ~ack_reg;
    assign wr_go             = AVS_WRITE_I & ack_reg;
    assign rd_go             = AVS_READ_I & ack_reg;
    assign busy              = enable_reg & start_reg;
    assign wmask             = lane_mask(AVS_BYTEENABLE_I);
    assign word_addr         = AVS_ADDRESS_I[5:2];

    // ack toggles so each request takes exactly two edges
    always @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req & ~ack_reg;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg [LIMIT_W-1:0] limit_next;
    reg [INDEX_W-1:0] index_next;
    reg [15:0]        idx_w;

    // next value of limit and index, software write blocked while busy
    always @* begin
        limit_next = limit_reg;
        index_next = index_reg;
        idx_w      = merge16({{(16-INDEX_W){1'b0}}, index_reg}, AVS_WRITEDATA_I[15:0], wmask);
        if (wr_go && !busy && word_addr == `TSS_OFS_LIMIT >> 2) begin // [RULE_03]
            limit_next = merge16(limit_reg, AVS_WRITEDATA_I[15:0], wmask); // [RULE_07]
        end
        if (busy && STEP_JUMP_I) begin
            index_next = STEP_JUMP_INDEX_I; // [RULE_05]
        end else if (busy && STEP_ADVANCE_I) begin
            index_next = index_reg + {{(INDEX_W-1){1'b0}}, 1'b1}; // [RULE_05]
        end else if (wr_go && !busy && word_addr == `TSS_OFS_INDEX >> 2) begin // [RULE_03]
            index_next = idx_w[INDEX_W-1:0]; // [RULE_04] [RULE_09]
        end
    end

    // state flops, all clear at reset
    always @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            limit_reg  <= `TSS_LIMIT_RST; // [RULE_09]
            index_reg  <= `TSS_INDEX_RST; // [RULE_09]
            enable_reg <= 1'b0;
            start_reg  <= 1'b0;
        end else begin
            limit_reg <= limit_next;
            index_reg <= index_next;
            if (wr_go && word_addr == `TSS_OFS_CTRL >> 2 && AVS_BYTEENABLE_I[0]) begin
                enable_reg <= AVS_WRITEDATA_I[`TSS_CTRL_EN_BIT];
                start_reg  <= AVS_WRITEDATA_I[`TSS_CTRL_ST_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // step queue
    // ----------------------------------------------------------------
    wire        q_wr;
    wire        q_win;
    wire [3:0]  q_addr;
    wire [15:0] q_wdata;

    // four queue words are mapped from the queue offset; writes blocked while busy
    assign q_win   = word_addr >= (`TSS_OFS_QUEUE >> 2)
                     && word_addr < (`TSS_OFS_QUEUE >> 2) + 4'h4;
    assign q_wr    = wr_go && !busy && q_win;
    assign q_addr  = word_addr - (`TSS_OFS_QUEUE >> 2);
    // byte lanes merged with the word already stored
    assign q_wdata = merge16(q_rdata, AVS_WRITEDATA_I[15:0], wmask);

    tss_step_queue #(
        .WORDS (`TSS_QUEUE_WORDS),
        .AW    (4)
    ) u_queue (
        .clk_i      (MCLK_I),
        .wr_i       (q_wr), // [RULE_08]
        .waddr_i    (q_addr),
        .wdata_i    (q_wdata),
        .raddr_i    (q_addr),
        .rdata_o    (q_rdata),
        .step_idx_i (index_reg), // [RULE_08]
        .step_o     (STEP_CMD_O) // [RULE_05]
    );

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    always @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            AVS_READDATA_O <= 32'h00000000;
        end else if (rd_go || (AVS_READ_I && !ack_reg)) begin
            case (word_addr)
                `TSS_OFS_LIMIT >> 2: AVS_READDATA_O <= {16'h0000, limit_reg};
                `TSS_OFS_INDEX >> 2: AVS_READDATA_O <= {27'h0000000, index_reg}; // [RULE_06]
                `TSS_OFS_CTRL >> 2:  AVS_READDATA_O <= {29'h00000000, busy, start_reg,
                                                        enable_reg};
                default:             AVS_READDATA_O <= q_win ? {16'h0000, q_rdata}
                                                             : 32'h00000000;
            endcase
        end
    end

    assign LOOP_LIMIT_O    = limit_reg; // [RULE_01]
    assign CNT0_AT_LIMIT_O = (CNT0_VALUE_I == limit_reg); // [RULE_02]
    assign STEP_INDEX_O    = index_reg;
    assign SEQ_BUSY_O      = busy;
    assign SEQ_ENABLE_O    = enable_reg;
    assign SEQ_START_O     = start_reg;
endmodule

`default_nettype wire

/* File: logic/tss_limptr_defs.vh */
// constants for the step sequencer limit and pointer register slice
// assumes inclusion by bare name from the design files under logic/
`ifndef TSS_LIMPTR_DEFS_VH
`define TSS_LIMPTR_DEFS_VH

// ----------------------------------------------------------------
// register byte addresses (word aligned)
// ----------------------------------------------------------------
`define TSS_OFS_LIMIT     4'h0
`define TSS_OFS_INDEX     4'h4
`define TSS_OFS_CTRL      4'h8
`define TSS_OFS_QUEUE     4'hC

// ----------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------
`define TSS_LIMIT_W       16
`define TSS_INDEX_W       5
`define TSS_LIMIT_RST     16'h0000
`define TSS_INDEX_RST     5'h00
`define TSS_CTRL_EN_BIT   0
`define TSS_CTRL_ST_BIT   1
`define TSS_CTRL_BSY_BIT  2
`define TSS_STEP_W        8
`define TSS_QUEUE_WORDS   16

`endif

/* File: logic/tss_step_queue.v */
// step queue: 16 words of two packed 8-bit step commands
// assumes writes are already gated by the caller; contents survive reset
`include "tss_limptr_defs.vh"
`default_nettype none

module tss_step_queue #(
    parameter WORDS = `TSS_QUEUE_WORDS,
    parameter AW    = 4
) (
    input  wire          clk_i,
    input  wire          wr_i,
    input  wire [AW-1:0] waddr_i,
    input  wire [15:0]   wdata_i,
    input  wire [AW-1:0] raddr_i,
    output wire [15:0]   rdata_o,
    input  wire [AW:0]   step_idx_i,
    output wire [7:0]    step_o
);
    reg [15:0] mem [0:WORDS-1];
    wire [15:0] sel_word;

    // storage write; no reset, contents are kept across resets
    always @(posedge clk_i) begin
        if (wr_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    assign rdata_o  = mem[raddr_i];
    assign sel_word = mem[step_idx_i[AW:1]];
    // odd index takes the upper byte, even the lower
    assign step_o   = step_idx_i[0] ? sel_word[15:8] : sel_word[7:0];
endmodule

`default_nettype wire
